/* logic/fft_pkg.sv */
package fft_pkg;
   // word and field widths
   localparam int DATA_W    = 12;
   localparam int FILT_W    = 3;
   localparam int TRIM_W    = 6;
   localparam int SET_W     = FILT_W + TRIM_W;
   localparam int CMD_LEN   = 16;
   localparam int CNT_W     = 5;
   // command field positions, first bit received ends up at the top
   localparam int HDR_MSB   = 15;
   localparam int HDR_LSB   = 14;
   localparam int FILT_MSB  = 13;
   localparam int FILT_LSB  = 11;
   localparam int TRIM_MSB  = 10;
   localparam int TRIM_LSB  = 5;
   localparam int ZERO_MSB  = 4;
   localparam int ZERO_LSB  = 1;
   localparam int PROG_BIT  = 0;
   localparam logic [1:0] CMD_HDR_WRITE = 2'h2;
   localparam logic [3:0] CMD_ZERO_FILL = 4'h0;
   localparam logic [CNT_W-1:0] CMD_LEN_CNT = 5'h10;
   // gain = (TRIM_BASE + code) / 2^TRIM_FRAC, mid code gives unity
   localparam logic [7:0]  TRIM_BASE  = 8'h60;
   localparam int          TRIM_FRAC  = 7;
   localparam logic [12:0] MID_SCALE  = 13'h0800;
   localparam logic [12:0] FULL_SCALE = 13'h0FFF;
   // reset values
   localparam logic [DATA_W-1:0] RESULT_RST = 12'h000;
   localparam logic [SET_W-1:0]  SET_RST    = 9'h000;
endpackage : fft_pkg

/* logic/fft_ewma.sv */
`timescale 1ns/1ps
// trim gain followed by the first-order averaging filter, one result per start
module fft_ewma
   import fft_pkg::*;
(
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_nrst,
   // sample request
   input  wire logic              i_start,
   input  wire logic [DATA_W-1:0] i_sample,
   input  wire logic [FILT_W-1:0] i_filt_code,
   input  wire logic [TRIM_W-1:0] i_trim_code,
   // result
   output logic      [DATA_W-1:0] o_result,
   output logic                   o_done
);
   logic signed [13:0] centered;
   logic signed [22:0] product;
   logic signed [13:0] scaled;
   logic signed [13:0] trimmed;
   logic signed [13:0] diff;
   logic signed [13:0] filt_nxt;
   logic [DATA_W-1:0]  prev_r;

   // gain trim
   // deviation from mid scale is scaled, so zero field stays at mid scale
   always_comb begin
      centered = $signed({1'b0, i_sample}) - $signed({1'b0, MID_SCALE});
      product  = centered * $signed({1'b0, TRIM_BASE + {2'b00, i_trim_code}});
      scaled   = 14'(product >>> TRIM_FRAC) + $signed({1'b0, MID_SCALE});
      if (scaled < 0) begin
         trimmed = '0;
      end else if (scaled > $signed({1'b0, FULL_SCALE})) begin
         trimmed = $signed({1'b0, FULL_SCALE});
      end else begin
         trimmed = scaled;
      end
   end

   always_comb begin
      diff     = trimmed - $signed({2'b00, prev_r});
      filt_nxt = $signed({2'b00, prev_r}) + (diff >>> i_filt_code);
   end

   // state kept
   // the filter code is not looked at here, so changing it keeps history
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         prev_r <= RESULT_RST;
      end else if (i_start) begin
         prev_r <= filt_nxt[DATA_W-1:0];
      end
   end

   // result mirrors the state, done marks the update
   assign o_result = prev_r;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_done <= 1'b0;
      end else begin
         o_done <= i_start;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   a_bypass_exact: assert property (i_start && i_filt_code == '0 |=> prev_r == $past(trimmed[DATA_W-1:0]))
      else $error("bypass result differs from trimmed sample");
   a_step_bounded: assert property (i_start && diff > 0
                                    |=> prev_r >= $past(prev_r) && prev_r <= $past(trimmed))
      else $error("filter step leaves the prev..sample span");
   a_state_held: assert property (!i_start |=> $stable(prev_r))
      else $error("filter state moved without a sample");
   a_gain_order: assert property (i_sample > MID_SCALE[DATA_W-1:0] && i_trim_code == '1
                                  |-> trimmed >= $signed({2'b00, i_sample}))
      else $error("top trim code does not raise sensitivity");
endmodule : fft_ewma

/* logic/fft_flux_filter.sv */
`timescale 1ns/1ps
module fft_flux_filter
   import fft_pkg::*;
(
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_nrst,
   // serial pins from the master
   input  wire logic              i_cs_n,
   input  wire logic              i_sck,
   input  wire logic              i_serial_in,
   // serial data out, driven while selected
   output logic                   o_serial_out,
   output logic                   o_serial_out_oe,
   // conversion result from the converter, same clock
   input  wire logic [DATA_W-1:0] i_conv_data,
   // one-time storage macro
   input  wire logic [SET_W-1:0]  i_otp_bits,
   output logic                   o_otp_prog_pulse,
   output logic      [SET_W-1:0]  o_otp_prog_bits,
   // active settings and filtered word
   output logic      [FILT_W-1:0] o_filt_code,
   output logic      [TRIM_W-1:0] o_trim_code,
   output logic      [DATA_W-1:0] o_result,
   output logic                   o_result_valid
);
   logic [2:0]         cs_sync_r;
   logic [2:0]         sck_sync_r;
   logic [1:0]         serial_in_sync_r;
   logic               cs_fall;
   logic               cs_rise;
   logic               sck_rise;
   logic               sck_fall;
   logic [CMD_LEN-1:0] cmd_r;
   logic [CNT_W-1:0]   bit_cnt_r;
   logic               write_ok;
   logic               pend_r;
   logic [SET_W-1:0]   pend_bits_r;
   logic               booted_r;
   logic               filt_done;
   logic [DATA_W-1:0]  filt_word;
   logic [DATA_W-1:0]  shift_r;

   // pins cross in through two flops; third stage only feeds edge detect
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cs_sync_r        <= 3'h7;
         sck_sync_r       <= 3'h0;
         serial_in_sync_r <= 2'h0;
      end else begin
         cs_sync_r        <= {cs_sync_r[1:0], i_cs_n};
         sck_sync_r       <= {sck_sync_r[1:0], i_sck};
         serial_in_sync_r <= {serial_in_sync_r[0], i_serial_in};
      end
   end

   assign cs_fall  = cs_sync_r[2] && !cs_sync_r[1];
   assign cs_rise  = !cs_sync_r[2] && cs_sync_r[1];
   assign sck_rise = !cs_sync_r[1] && !sck_sync_r[2] && sck_sync_r[1];
   assign sck_fall = !cs_sync_r[1] && sck_sync_r[2] && !sck_sync_r[1];

   // command capture
   // bits past the sixteenth are ignored, a read simply clocks more
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cmd_r     <= '0;
         bit_cnt_r <= '0;
      end else if (cs_fall) begin
         bit_cnt_r <= '0;
      end else if (sck_rise && bit_cnt_r < CMD_LEN_CNT) begin
         cmd_r     <= {cmd_r[CMD_LEN-2:0], serial_in_sync_r[1]};
         bit_cnt_r <= bit_cnt_r + 5'h01;
      end
   end

   assign write_ok = cs_rise && bit_cnt_r == CMD_LEN_CNT
                     && cmd_r[HDR_MSB:HDR_LSB] == CMD_HDR_WRITE
                     && cmd_r[ZERO_MSB:ZERO_LSB] == CMD_ZERO_FILL;

   // preview overrides
   // storage is read on the first edge after release, then writes take over
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         booted_r    <= 1'b0;
         o_filt_code <= SET_RST[SET_W-1:TRIM_W];
         o_trim_code <= SET_RST[TRIM_W-1:0];
      end else if (!booted_r) begin
         booted_r    <= 1'b1;
         o_filt_code <= i_otp_bits[SET_W-1:TRIM_W];
         o_trim_code <= i_otp_bits[TRIM_W-1:0];
      end else if (write_ok) begin
         o_filt_code <= cmd_r[FILT_MSB:FILT_LSB];
         o_trim_code <= cmd_r[TRIM_MSB:TRIM_LSB];
      end
   end

   // relies on next command
   // the arm is held until the next select fall; the follow-up is a read
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pend_r      <= 1'b0;
         pend_bits_r <= SET_RST;
      end else if (cs_fall) begin
         pend_r      <= 1'b0;
      end else if (write_ok && cmd_r[PROG_BIT]) begin
         pend_r      <= 1'b1;
         pend_bits_r <= {cmd_r[FILT_MSB:FILT_LSB], cmd_r[TRIM_MSB:TRIM_LSB]};
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_otp_prog_pulse <= 1'b0;
         o_otp_prog_bits  <= SET_RST;
      end else begin
         o_otp_prog_pulse <= cs_fall && pend_r;
         if (cs_fall && pend_r) begin
            o_otp_prog_bits <= pend_bits_r | i_otp_bits;
         end
      end
   end

   fft_ewma u_ewma (
      .i_core_clk  (i_core_clk),
      .i_nrst      (i_nrst),
      .i_start     (cs_fall),
      .i_sample    (i_conv_data),
      .i_filt_code (o_filt_code),
      .i_trim_code (o_trim_code),
      .o_result    (filt_word),
      .o_done      (filt_done)
   );

   // result word and its strobe, registered at the top
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_result       <= RESULT_RST;
         o_result_valid <= 1'b0;
      end else begin
         o_result_valid <= filt_done;
         if (filt_done) begin
            o_result <= filt_word;
         end
      end
   end

   // output shifter, msb first, advanced on falling serial clock
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         shift_r         <= RESULT_RST;
         o_serial_out    <= 1'b0;
         o_serial_out_oe <= 1'b0;
      end else begin
         o_serial_out_oe <= !cs_sync_r[1];
         if (filt_done) begin
            shift_r      <= filt_word;
            o_serial_out <= filt_word[DATA_W-1];
         end else if (sck_fall) begin
            shift_r      <= {shift_r[DATA_W-2:0], 1'b0};
            o_serial_out <= shift_r[DATA_W-2];
         end
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   a_prog_pulse_time: assert property (cs_fall && pend_r |=> o_otp_prog_pulse)
      else $error("programming pulse missing after select fall");
   a_prog_needs_arm: assert property (o_otp_prog_pulse |-> $past(pend_r) && $past(cs_fall))
      else $error("programming pulse without armed write");
   a_otp_monotone: assert property (o_otp_prog_pulse
                                    |-> (o_otp_prog_bits & $past(i_otp_bits)) == $past(i_otp_bits))
      else $error("programming would clear a stored bit");
   a_preview_apply: assert property (booted_r && write_ok |=> o_filt_code == $past(cmd_r[FILT_MSB:FILT_LSB])
                                     && o_trim_code == $past(cmd_r[TRIM_MSB:TRIM_LSB]))
      else $error("write did not update active settings");
   a_preview_no_prog: assert property (write_ok && !cmd_r[PROG_BIT] && !pend_r
                                       |=> !pend_r ##1 !o_otp_prog_pulse)
      else $error("preview write armed programming");
   a_bad_header: assert property (booted_r && cs_rise && cmd_r[HDR_MSB:HDR_LSB] != CMD_HDR_WRITE
                                  |=> $stable(o_filt_code) && $stable(o_trim_code))
      else $error("non-write command changed settings");
   a_short_cmd: assert property (booted_r && cs_rise && bit_cnt_r != CMD_LEN_CNT
                                 |=> $stable(o_filt_code) && $stable(o_trim_code))
      else $error("short command changed settings");
   a_boot_load: assert property ($rose(booted_r) |-> o_filt_code == $past(i_otp_bits[SET_W-1:TRIM_W])
                                 && o_trim_code == $past(i_otp_bits[TRIM_W-1:0]))
      else $error("stored settings not loaded at boot");
   a_pulse_single: assert property (o_otp_prog_pulse |=> !o_otp_prog_pulse)
      else $error("programming pulse longer than one cycle");
   a_sample_rate: assert property (cs_fall |-> ##2 o_result_valid)
      else $error("no result two cycles after select fall");
   a_result_hold: assert property (!o_result_valid |-> $stable(o_result))
      else $error("result word moved without its strobe");

   c_preview: cover property (write_ok && !cmd_r[PROG_BIT]);
   c_program: cover property (o_otp_prog_pulse);
   c_filtered: cover property (o_result_valid && o_filt_code != '0);
   c_boot_stored: cover property ($rose(booted_r) && i_otp_bits != '0);
endmodule : fft_flux_filter

/* verif/fft_master_model.sv */
`timescale 1ns/1ps
// serial master: one command per select, clock stands still between frames
module fft_master_model (
   // clock
   input  wire logic i_core_clk,
   // serial pins towards the sensor
   output logic      o_cs_n,
   output logic      o_sck,
   output logic      o_serial_in,
   input  wire logic i_serial_out
);
   logic [11:0] rd_word;
   initial begin
      o_cs_n      = 1'b1;
      o_sck       = 1'b0;
      o_serial_in = 1'b0;
   end
   // released data line toggles so a stale level is never mistaken for data
   always @(posedge i_core_clk) begin
      if (o_cs_n) o_serial_in <= ~o_serial_in;
   end
   // bit order: header, filter, trim, zero fill, flag
   // a zero command follows any programming write (caller sends it)
   task automatic send(input logic [15:0] cmd, input int nbits, input int half);
      @(posedge i_core_clk) o_cs_n <= 1'b0;
      repeat (8) @(posedge i_core_clk);
      for (int i = 0; i < nbits; i++) begin
         o_serial_in <= cmd[15-i];
         repeat (half) @(posedge i_core_clk);
         o_sck <= 1'b1;
         repeat (half) @(posedge i_core_clk);
         if (i < 12) rd_word[11-i] = i_serial_out; // stable since the last fall
         o_sck <= 1'b0;
      end
      repeat (half) @(posedge i_core_clk);
      o_cs_n <= 1'b1;
      repeat (10) @(posedge i_core_clk);
   endtask : send
endmodule : fft_master_model

/* verif/fft_flux_filter_bench.sv */
`timescale 1ns/1ps
module fft_flux_filter_bench;
   import fft_pkg::*;
   logic              clk, nrst, cs_n, sck, ser_in, ser_out, ser_out_oe, ppulse, rvalid;
   logic [DATA_W-1:0] conv, res;
   logic [SET_W-1:0]  otp_r = '0;
   logic [SET_W-1:0]  pbits, pb_now;
   logic [FILT_W-1:0] fcode;
   logic [TRIM_W-1:0] tcode;
   logic [15:0]       lfsr_r;
   int                n_mismatch, total_checks, n_pulse, n_valid, cyc, prev_e, ef, et, last;

   fft_flux_filter i_dut (.i_core_clk(clk), .i_nrst(nrst), .i_cs_n(cs_n), .i_sck(sck),
      .i_serial_in(ser_in), .o_serial_out(ser_out), .o_serial_out_oe(ser_out_oe), .i_conv_data(conv),
      .i_otp_bits(otp_r), .o_otp_prog_pulse(ppulse), .o_otp_prog_bits(pb_now),
      .o_filt_code(fcode), .o_trim_code(tcode), .o_result(res), .o_result_valid(rvalid));
   // undriven output line reads as the inverse, so a missing enable corrupts the word
   fft_master_model i_master (.i_core_clk(clk), .o_cs_n(cs_n), .o_sck(sck), .o_serial_in(ser_in),
      .i_serial_out(ser_out_oe ? ser_out : ~ser_out));

   always #50 clk = ~clk;
   // storage model: a pulse only ever ORs bits in
   always @(posedge clk) begin
      cyc++;
      if (rvalid === 1'b1) n_valid++;
      if (ppulse === 1'b1) begin
         n_pulse++;
         pbits = pb_now;
         otp_r <= otp_r | pb_now;
      end
      if (cyc == 40000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   // trim gain about mid scale, clamped to the word
   function automatic int exp_trim(input int x, input int c);
      int v;
      v = (((x - 2048) * (96 + c)) >>> 7) + 2048;
      return (v < 0) ? 0 : (v > 4095) ? 4095 : v;
   endfunction : exp_trim
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
      total_checks++;
      if (got !== want) begin
         n_mismatch++;
         $display("BAD t=%0t %s got %0h want %0h", $time, what, got, want);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test

   task automatic do_reset();
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      prev_e = 0;
      ef = otp_r[8:6];
      et = otp_r[5:0];
      check({fcode, tcode}, otp_r, "boot settings");
   endtask : do_reset

   // one select frame: sample taken with the settings active at its start
   task automatic frame(input logic [15:0] cmd, input int nb, input int x, input int half);
      int v0;
      @(posedge clk) conv <= x[DATA_W-1:0];
      v0 = n_valid;
      prev_e = prev_e + ((exp_trim(x, et) - prev_e) >>> ef);
      i_master.send(cmd, nb, half);
      check(res, prev_e, "filtered word");
      check(n_valid - v0, 1, "one result per select");
      if (cmd == 16'h0000) check(i_master.rd_word, prev_e, "serial word");
      if (nb == 16 && cmd[15:14] == 2'b10 && cmd[4:1] == 4'h0) begin
         ef = cmd[13:11];
         et = cmd[10:5];
      end
      check({fcode, tcode}, {ef[2:0], et[5:0]}, "active settings");
   endtask : frame

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      conv = '0;
      lfsr_r = 16'h0033;
      do_reset();
      frame(16'b10_010_010000_0000_0, 16, 2048, 3);
      check(n_pulse, 0, "preview programmed");
      // every filter code, random samples at unity trim
      for (int f = 0; f < 8; f++) begin
         frame({2'b10, f[2:0], 6'd32, 5'd0}, 16, 2048, 3);
         for (int k = 0; k < 4; k++) begin
            lfsr_r = lfsr_next(lfsr_r);
            frame(16'h0000, 16, lfsr_r[11:0], (k == 3) ? 6 : 3);
         end
      end
      // trim sweep, each frame samples with the previous code
      for (int c = 0; c < 64; c++) begin
         frame({5'b10_000, c[5:0], 5'd0}, 16, 3072, 3);
         if (c > 1) check(res > last, 1, "sensitivity rises");
         last = res;
      end
      // malformed writes leave settings alone
      frame(16'b11_101_000001_0000_0, 16, 2048, 3);
      frame(16'b10_101_000001_0100_0, 16, 2048, 3);
      frame(16'b10_101_000001_0000_0, 15, 2048, 3);
      // program trim alone; pulse waits for the next select
      frame(16'b10_000_001100_0000_1, 16, 2048, 3);
      check(n_pulse, 0, "pulse too early");
      frame(16'h0000, 16, 2048, 6);
      check(n_pulse, 1, "one program pulse");
      check(pbits, 9'b000_001100, "programmed bits");
      frame(16'b10_011_001100_0000_0, 16, 2048, 3);
      frame(16'b10_001_000011_0000_1, 16, 2048, 3);
      frame(16'h0000, 16, 2048, 3);
      check(pbits, 9'b001_001111, "bits only added");
      do_reset();
      frame(16'h0000, 16, 1024, 3);
      frame(16'b10_000_100000_0000_0, 16, 3072, 3);
      frame(16'h0000, 16, 3000, 3);
      check(n_pulse, 2, "previews programmed");
      end_of_test();
   end
endmodule : fft_flux_filter_bench
